// ===== inc/twu_pkg.sv
// Constants for the timer and watchdog unit
package twu_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_NMI_EN = 12'hA43;
  localparam logic [11:0] IDX_DIV_LO = 12'hA80;
  localparam logic [11:0] IDX_DIV_HI = 12'hA81;
  localparam logic [11:0] IDX_TCTRL = 12'hA84;
  localparam logic [11:0] IDX_WPER_LO = 12'hA86;
  localparam logic [11:0] IDX_WPER_HI = 12'hA87;
  localparam logic [11:0] IDX_T0PER_LO = 12'hA88;
  localparam logic [11:0] IDX_T0PER_HI = 12'hA89;
  localparam logic [11:0] IDX_T1PER = 12'hA8A;
  localparam logic [11:0] IDX_WCLR_LO = 12'hA8C;
  localparam logic [11:0] IDX_WCLR_HI = 12'hA8D;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hA90;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hA91;

  // Reset values
  localparam logic [7:0] RST_NMI_EN = 8'h80;
  localparam logic [11:0] RST_DIV = 12'h024;
  localparam logic [7:0] RST_TCTRL = 8'h00;
  localparam logic [15:0] RST_WPER = 16'h0000;
  localparam logic [11:0] RST_T0PER = 12'h3E8;
  localparam logic [7:0] RST_T1PER = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // Field positions
  localparam int B_T0_EN = 0;
  localparam int B_T1_EN = 1;
  localparam int B_WDT_EN = 2;
  localparam int B_WDT_ACT = 3;
  localparam int B_NMI_EN = 7;
  localparam int B_ST_WDT = 1;
  localparam int B_ST_T0 = 2;
  localparam int B_ST_T1 = 3;

  // Watchdog restart key
  localparam logic [15:0] WDT_KEY = 16'h2371;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/twu_top.sv
// Timer tick divider, two period timers and watchdog with AXI4-Lite registers
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Tick divides clock by field plus one
// - One tick drives both timers and watchdog
// - Watchdog counts only when enabled, reset off
// - Watchdog counts to period minus two, then acts on the next tick
// - First timeout P-2..P-1 ticks, later P-1
// - Key 2371h written to clear restarts watchdog
// - Action bit picks interrupt or system reset
// - Timer 0 counts only when enabled
// - Timer 0 expiry sets status bit 2
// - Timer 1 8-bit period sets status bit 3
// - NMI on timer 0 expiry when enabled
module twu_top import twu_pkg::*; #(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  output logic NMI,
  output logic WATCHDOG_IRQ_LINE,
  output logic SYS_RESET_OUT
);

  // Bus slave state
  logic aw_full_q, w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Register state
  logic [7:0] nmi_en_q, tctrl_q, t1per_q, wclr_lo_q;
  logic [11:0] div_q, t0per_q;
  logic [15:0] wper_q;
  logic [3:0] stat_q, mask_q;
  logic [3:0] stat_d;

  // Counters
  logic [11:0] div_cnt_q, t0_cnt_q;
  logic [7:0] t1_cnt_q;
  logic [15:0] wdt_cnt_q;
  logic irq_q, nmi_q, wdt_line_q, sysrst_q;

  // Write path decode
  wire do_wr = aw_full_q && w_full_q && !bvalid_q;
  wire [ADDR_W-3:0] wr_idx = awaddr_q[ADDR_W-1:2];
  wire wr_lane0 = do_wr && wstrb_q[0];
  wire [7:0] wbyte = wdata_q[7:0];
  wire sel_nmi = wr_idx == (ADDR_W-2)'(IDX_NMI_EN);
  wire sel_dlo = wr_idx == (ADDR_W-2)'(IDX_DIV_LO);
  wire sel_dhi = wr_idx == (ADDR_W-2)'(IDX_DIV_HI);
  wire sel_tc = wr_idx == (ADDR_W-2)'(IDX_TCTRL);
  wire sel_wlo = wr_idx == (ADDR_W-2)'(IDX_WPER_LO);
  wire sel_whi = wr_idx == (ADDR_W-2)'(IDX_WPER_HI);
  wire sel_t0lo = wr_idx == (ADDR_W-2)'(IDX_T0PER_LO);
  wire sel_t0hi = wr_idx == (ADDR_W-2)'(IDX_T0PER_HI);
  wire sel_t1 = wr_idx == (ADDR_W-2)'(IDX_T1PER);
  wire sel_clo = wr_idx == (ADDR_W-2)'(IDX_WCLR_LO);
  wire sel_chi = wr_idx == (ADDR_W-2)'(IDX_WCLR_HI);
  wire sel_st = wr_idx == (ADDR_W-2)'(IDX_IRQ_STAT);
  wire sel_mk = wr_idx == (ADDR_W-2)'(IDX_IRQ_MASK);
  wire wr_hit = sel_nmi | sel_dlo | sel_dhi | sel_tc | sel_wlo | sel_whi | sel_t0lo | sel_t0hi
    | sel_t1 | sel_clo | sel_chi | sel_st | sel_mk;

  // Key check: either clear byte completes the key against the other stored byte
  logic [7:0] wclr_hi_byte_q;
  wire clr_lo_wr = wr_lane0 && sel_clo;
  wire clr_hi_wr = wr_lane0 && sel_chi;
  wire key_hit = (clr_hi_wr && {wbyte, wclr_lo_q} == WDT_KEY)
    || (clr_lo_wr && {wclr_hi_byte_q, wbyte} == WDT_KEY);

  // Read path decode
  wire [ADDR_W-3:0] rd_idx = S_AXI_ARADDR[ADDR_W-1:2];
  wire do_rd = S_AXI_ARVALID && !rvalid_q;
  wire [31:0] rd_word =
    (rd_idx == (ADDR_W-2)'(IDX_NMI_EN)) ? {24'h000000, nmi_en_q} :
    (rd_idx == (ADDR_W-2)'(IDX_DIV_LO)) ? {24'h000000, div_q[7:0]} :
    (rd_idx == (ADDR_W-2)'(IDX_DIV_HI)) ? {28'h0000000, div_q[11:8]} :
    (rd_idx == (ADDR_W-2)'(IDX_TCTRL)) ? {24'h000000, tctrl_q} :
    (rd_idx == (ADDR_W-2)'(IDX_WPER_LO)) ? {24'h000000, wper_q[7:0]} :
    (rd_idx == (ADDR_W-2)'(IDX_WPER_HI)) ? {24'h000000, wper_q[15:8]} :
    (rd_idx == (ADDR_W-2)'(IDX_T0PER_LO)) ? {24'h000000, t0per_q[7:0]} :
    (rd_idx == (ADDR_W-2)'(IDX_T0PER_HI)) ? {28'h0000000, t0per_q[11:8]} :
    (rd_idx == (ADDR_W-2)'(IDX_T1PER)) ? {24'h000000, t1per_q} :
    (rd_idx == (ADDR_W-2)'(IDX_IRQ_STAT)) ? {28'h0000000, stat_q} :
    (rd_idx == (ADDR_W-2)'(IDX_IRQ_MASK)) ? {28'h0000000, mask_q} : 32'h00000000;
  // Clear registers are write-only and read as zero
  wire rd_hit = (rd_idx == (ADDR_W-2)'(IDX_NMI_EN)) || (rd_idx == (ADDR_W-2)'(IDX_DIV_LO))
    || (rd_idx == (ADDR_W-2)'(IDX_DIV_HI)) || (rd_idx == (ADDR_W-2)'(IDX_TCTRL))
    || (rd_idx == (ADDR_W-2)'(IDX_WPER_LO)) || (rd_idx == (ADDR_W-2)'(IDX_WPER_HI))
    || (rd_idx == (ADDR_W-2)'(IDX_T0PER_LO)) || (rd_idx == (ADDR_W-2)'(IDX_T0PER_HI))
    || (rd_idx == (ADDR_W-2)'(IDX_T1PER)) || (rd_idx == (ADDR_W-2)'(IDX_WCLR_LO))
    || (rd_idx == (ADDR_W-2)'(IDX_WCLR_HI)) || (rd_idx == (ADDR_W-2)'(IDX_IRQ_STAT))
    || (rd_idx == (ADDR_W-2)'(IDX_IRQ_MASK));

  // Tick and expiry terms
  wire tick = div_cnt_q == div_q;
  wire t0_en = tctrl_q[B_T0_EN];
  wire t1_en = tctrl_q[B_T1_EN];
  wire wdt_en = tctrl_q[B_WDT_EN];
  wire wdt_act = tctrl_q[B_WDT_ACT];
  // Terminal at P-2 counts P-1 ticks from 0; zero period wraps to the long wait
  wire [15:0] wdt_term = wper_q - 16'h0002;
  wire [11:0] t0_term = t0per_q - 12'h002;
  wire [7:0] t1_term = t1per_q - 8'h02;
  wire wdt_exp = wdt_en && tick && wdt_cnt_q == wdt_term;
  wire t0_exp = t0_en && tick && t0_cnt_q == t0_term;
  wire t1_exp = t1_en && tick && t1_cnt_q == t1_term;
  wire [3:0] stat_set = {t1_exp, t0_exp, wdt_exp && !wdt_act, 1'b0};
  wire [3:0] stat_clr = (wr_lane0 && sel_st) ? wbyte[3:0] : 4'h0;

  // Set wins over a write-one clear in the same cycle
  always_comb begin
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  // AXI write channel
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (do_rd) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // Configuration registers, only byte lane 0 is meaningful
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      nmi_en_q <= RST_NMI_EN;
      div_q <= RST_DIV;
      tctrl_q <= RST_TCTRL;
      wper_q <= RST_WPER;
      t0per_q <= RST_T0PER;
      t1per_q <= RST_T1PER;
      wclr_lo_q <= 8'h00;
      wclr_hi_byte_q <= 8'h00;
      mask_q <= RST_IRQ_MASK;
      stat_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
      if (wr_lane0) begin
        if (sel_nmi) nmi_en_q <= {wbyte[7], 7'h00};
        if (sel_dlo) div_q[7:0] <= wbyte;
        if (sel_dhi) div_q[11:8] <= wbyte[3:0];
        if (sel_tc) tctrl_q <= {4'h0, wbyte[3:0]};
        if (sel_wlo) wper_q[7:0] <= wbyte;
        if (sel_whi) wper_q[15:8] <= wbyte;
        if (sel_t0lo) t0per_q[7:0] <= wbyte;
        if (sel_t0hi) t0per_q[11:8] <= wbyte[3:0];
        if (sel_t1) t1per_q <= wbyte;
        if (sel_clo) wclr_lo_q <= wbyte;
        if (sel_chi) wclr_hi_byte_q <= wbyte;
        if (sel_mk) mask_q <= wbyte[3:0];
      end
    end
  end

  // Tick divider, ratio is field plus one
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      div_cnt_q <= 12'h000;
    end else if (tick || div_cnt_q > div_q) begin
      div_cnt_q <= 12'h000;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
    end
  end

  // Timers hold at zero while disabled, so the first interval loses the partial tick
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      t0_cnt_q <= 12'h000;
      t1_cnt_q <= 8'h00;
    end else begin
      if (!t0_en) t0_cnt_q <= 12'h000;
      else if (t0_exp) t0_cnt_q <= 12'h000;
      else if (tick) t0_cnt_q <= t0_cnt_q + 12'h001;
      if (!t1_en) t1_cnt_q <= 8'h00;
      else if (t1_exp) t1_cnt_q <= 8'h00;
      else if (tick) t1_cnt_q <= t1_cnt_q + 8'h01;
    end
  end

  // Watchdog counter
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      wdt_cnt_q <= 16'h0000;
    end else if (!wdt_en) begin
      wdt_cnt_q <= 16'h0000;
    end else if (key_hit || wdt_exp) begin
      wdt_cnt_q <= 16'h0000;
    end else if (tick) begin
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
    end
  end

  // Output flops
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      irq_q <= 1'b0;
      nmi_q <= 1'b0;
      wdt_line_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
      nmi_q <= t0_exp && nmi_en_q[B_NMI_EN];
      wdt_line_q <= stat_d[B_ST_WDT];
      sysrst_q <= wdt_exp && wdt_act;
    end
  end

  assign S_AXI_AWREADY = !aw_full_q;
  assign S_AXI_WREADY = !w_full_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign IRQ = irq_q;
  assign NMI = nmi_q;
  assign WATCHDOG_IRQ_LINE = wdt_line_q;
  assign SYS_RESET_OUT = sysrst_q;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_key_write;
    key_hit && wdt_en;
  endsequence
  sequence s_other_clear;
    (clr_lo_wr || clr_hi_wr) && !key_hit && wdt_en && !tick && !wdt_exp;
  endsequence

  AST_DIV_WRAP: assert property (tick |=> div_cnt_q == 12'h000)
    else $error("divider did not wrap after tick");
  AST_DIV_STEP: assert property (!tick && div_cnt_q < div_q && $stable(div_q) |=> div_cnt_q == $past(div_cnt_q) + 12'h001)
    else $error("divider did not step");
  AST_T0_TICK: assert property (t0_en && !tick |=> $stable(t0_cnt_q))
    else $error("timer 0 moved without a tick");
  AST_WDT_OFF: assert property (!wdt_en |=> wdt_cnt_q == 16'h0000 && !SYS_RESET_OUT)
    else $error("disabled watchdog counted");
  AST_WDT_TERM: assert property (wdt_exp |-> wdt_cnt_q == wper_q - 16'h0002)
    else $error("watchdog expired at wrong count");
  AST_WDT_KEY: assert property (s_key_write |=> wdt_cnt_q == 16'h0000)
    else $error("key write did not restart watchdog");
  AST_WDT_NOKEY: assert property (s_other_clear |=> wdt_cnt_q == $past(wdt_cnt_q))
    else $error("non-key clear disturbed watchdog");
  AST_WDT_IRQ: assert property (wdt_exp && !wdt_act |=> stat_q[B_ST_WDT] ##1 WATCHDOG_IRQ_LINE)
    else $error("watchdog interrupt missing");
  AST_WDT_RST: assert property (wdt_exp && wdt_act |=> SYS_RESET_OUT && (!stat_q[B_ST_WDT] || $past(stat_q[B_ST_WDT])))
    else $error("watchdog reset missing");
  AST_T0_STAT: assert property (t0_exp |=> stat_q[B_ST_T0])
    else $error("timer 0 status not set");
  AST_T1_STAT: assert property (t1_exp |=> stat_q[B_ST_T1] && t1_cnt_q == 8'h00)
    else $error("timer 1 status not set");
  AST_NMI: assert property (t0_exp |=> NMI == $past(nmi_en_q[B_NMI_EN]))
    else $error("nmi does not follow timer 0 expiry");

endmodule // twu_top

// ===== tb/tb.sv
// Self-checking bench for the timer and watchdog unit
`timescale 1ns/1ps
module tb;
  import twu_pkg::*;
  logic SYS_CLK, NRST, IRQ, NMI, WATCHDOG_IRQ_LINE, SYS_RESET_OUT;
  logic [15:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int nmi_cnt, nmi_last, nmi_gap, rst_last, rst_gap, wd_cnt;

  twu_top DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ),
    .NMI(NMI), .WATCHDOG_IRQ_LINE(WATCHDOG_IRQ_LINE), .SYS_RESET_OUT(SYS_RESET_OUT));

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  // Pulse spacing in clocks, taken from the last two pulses
  always @(posedge SYS_CLK) begin
    cyc++;
    if (NMI === 1'b1) begin
      nmi_cnt++;
      nmi_gap = cyc - nmi_last;
      nmi_last = cyc;
    end
    if (SYS_RESET_OUT === 1'b1) begin
      rst_gap = cyc - rst_last;
      rst_last = cyc;
    end
    if (WATCHDOG_IRQ_LINE === 1'b1) wd_cnt++;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] strb = 4'h1);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    S_AXI_AWADDR <= {2'b00, idx, 2'b00};
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_WSTRB <= strb;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!(aw && w) && n < 50) begin
      @(posedge SYS_CLK);
      n++;
      if (!aw && S_AXI_AWREADY === 1'b1) begin
        aw = 1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w && S_AXI_WREADY === 1'b1) begin
        w = 1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (S_AXI_BVALID !== 1'b1 && n < 50);
    S_AXI_BREADY <= 1'b0;
    chk({S_AXI_BVALID, S_AXI_BRESP}, {1'b1, er}, "write response");
    @(posedge SYS_CLK);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] ex, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    S_AXI_ARADDR <= {2'b00, idx, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (S_AXI_ARREADY !== 1'b1 && n < 50);
    S_AXI_ARVALID <= 1'b0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (S_AXI_RVALID !== 1'b1 && n < 50);
    S_AXI_RREADY <= 1'b0;
    chk({S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA}, {1'b1, er, 24'h000000, ex}, "read");
    @(posedge SYS_CLK);
  endtask

  task automatic t_regs;
    logic [11:0] ri [9] = '{IDX_NMI_EN, IDX_DIV_LO, IDX_DIV_HI, IDX_TCTRL, IDX_WPER_LO, IDX_WPER_HI,
                            IDX_T0PER_LO, IDX_T0PER_HI, IDX_T1PER};
    logic [7:0] rv [9] = '{8'h80, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE8, 8'h03, 8'h00};
    chk({IRQ, NMI, WATCHDOG_IRQ_LINE, SYS_RESET_OUT}, 4'h0, "outputs after reset");
    for (int i = 0; i < 9; i++) rd(ri[i], rv[i]);
    rd(IDX_WCLR_LO, 8'h00);
    rd(IDX_WCLR_HI, 8'h00);
    rd(12'hA85, 8'h00, RESP_SLVERR);
    wr(12'hA85, 8'hFF, RESP_SLVERR);
    wr(IDX_T1PER, 8'h5A);
    wr(IDX_T1PER, 8'hFF, RESP_OKAY, 4'h0);
    rd(IDX_T1PER, 8'h5A);
  endtask

  task automatic t_timer0;
    logic [7:0] dv [3] = '{8'h01, 8'h02, 8'h00};
    logic [7:0] ph [3] = '{8'h00, 8'h00, 8'h01};
    logic [7:0] pl [3] = '{8'h06, 8'h06, 8'h02};
    int per;
    for (int i = 0; i < 3; i++) begin
      per = {ph[i], pl[i]};
      wr(IDX_DIV_LO, dv[i]);
      wr(IDX_T0PER_LO, pl[i]);
      wr(IDX_T0PER_HI, ph[i]);
      wr(IDX_TCTRL, 8'h01);
      nmi_gap = 0;
      idle(2 * per * (dv[i] + 1) + 20);
      chk(nmi_gap, (per - 1) * (dv[i] + 1), "timer 0 spacing");
      wr(IDX_TCTRL, 8'h00);
    end
    wr(IDX_NMI_EN, 8'h00);
    wr(IDX_T0PER_HI, 8'h00);
    nmi_cnt = 0;
    wr(IDX_TCTRL, 8'h01);
    idle(20);
    wr(IDX_TCTRL, 8'h00);
    chk(nmi_cnt, 0, "nmi while disabled");
    rd(IDX_IRQ_STAT, 8'h04);
    wr(IDX_IRQ_STAT, 8'h0E);
    rd(IDX_IRQ_STAT, 8'h00);
  endtask

  task automatic t_timer1;
    int n;
    n = 0;
    wr(IDX_IRQ_MASK, 8'h08);
    wr(IDX_T1PER, 8'h04);
    wr(IDX_TCTRL, 8'h02);
    while (IRQ !== 1'b1 && n < 40) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk(IRQ, 1'b1, "timer 1 interrupt");
    wr(IDX_TCTRL, 8'h00);
    rd(IDX_IRQ_STAT, 8'h08);
    wr(IDX_IRQ_MASK, 8'h00);
    idle(2);
    chk(IRQ, 1'b0, "masked interrupt");
    wr(IDX_IRQ_STAT, 8'h08);
    rd(IDX_IRQ_STAT, 8'h00);
  endtask

  task automatic t_wdog;
    wr(IDX_DIV_LO, 8'h03);
    wr(IDX_WPER_LO, 8'h08);
    wr(IDX_WPER_HI, 8'h00);
    wr(IDX_WCLR_HI, 8'h23);
    wr(IDX_WCLR_LO, 8'h71);
    wr(IDX_IRQ_MASK, 8'h02);
    wd_cnt = 0;
    wr(IDX_TCTRL, 8'h04);
    repeat (12) wr(IDX_WCLR_LO, 8'h71);
    chk(wd_cnt, 0, "time-out despite key");
    repeat (8) wr(IDX_WCLR_HI, 8'h00);
    chk(wd_cnt != 0, 1'b1, "no time-out after wrong key");
    chk(IRQ, 1'b1, "watchdog interrupt");
    wr(IDX_TCTRL, 8'h00);
    rd(IDX_IRQ_STAT, 8'h02);
    wr(IDX_IRQ_STAT, 8'h02);
    idle(2);
    wd_cnt = 0;
    rst_gap = 0;
    wr(IDX_TCTRL, 8'h0C);
    idle(80);
    wr(IDX_TCTRL, 8'h00);
    chk(rst_gap, 7 * 4, "watchdog reset spacing");
    chk(wd_cnt, 0, "interrupt on reset action");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    NRST = 1'b0;
    S_AXI_AWADDR = '0;
    S_AXI_ARADDR = '0;
    S_AXI_WDATA = '0;
    S_AXI_WSTRB = 4'h0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {nmi_cnt, nmi_last, nmi_gap, rst_last, rst_gap, wd_cnt} = '0;
    repeat (8) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    t_regs;
    t_timer0;
    t_timer1;
    t_wdog;
    conclude;
  end

  // Whole run is near 1000 clocks; allow ample margin
  initial begin
    #400000;
    n_fail++;
    conclude;
  end
endmodule // tb
